/* File: shared/prfs_pkg.sv */
package prfs_pkg;
  // Timing constants
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned CFG_REL_CYCLES = 32;
  localparam int unsigned SIGDET_MS = 3;
  localparam int unsigned SIGDET_CYCLES = SIGDET_MS * 1000 * CLK_MHZ;
  localparam int unsigned TXPLL_CYCLES = 127;
  localparam logic [2:0] RXSTAT_DETECTED = 3'h3;
  localparam int unsigned NUM_FUNC = 4;
  // Clock frequency codes (62.5/125/250 MHz as an encoded select)
  localparam logic [1:0] CLKSEL_62M5 = 2'h0;
  localparam logic [1:0] CLKSEL_125M = 2'h1;
  localparam logic [1:0] CLKSEL_250M = 2'h2;
  localparam logic [1:0] GEN1 = 2'h0;
  localparam logic [1:0] GEN2 = 2'h1;
  localparam logic [1:0] GEN3 = 2'h2;

  typedef enum logic [3:0] {
    PRFS_LT_QUIET = 4'h1,
    PRFS_LT_ACTIVE = 4'h2,
    PRFS_LT_POLL = 4'h4,
    PRFS_LT_IDLE = 4'h8
  } prfs_lt_e;

  typedef enum logic [3:0] {
    PRFS_RS_HOLD = 4'h1,
    PRFS_RS_WAIT = 4'h2,
    PRFS_RS_COUNT = 4'h4,
    PRFS_RS_RUN = 4'h8
  } prfs_rs_e;

  // Link configuration
  typedef struct packed {
    logic [3:0] width;
    logic [1:0] rate;
    logic wide_if;
  } prfs_cfg_s;

  // PHY status, receive side and transmit PLL lock
  typedef struct packed {
    logic phystatus;
    logic [2:0] rxstatus;
    logic sigdet;
    logic rx_locked;
    logic tx_locked;
  } prfs_phy_s;
endpackage

/* File: hdl/prfs_flr_chan.sv */
`timescale 1ns/1ps
// Per-function reset handshake
module prfs_flr_chan (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_flr_req,
  input wire logic i_done,
  output logic o_clear_ctl,
  output logic o_active
);
  import prfs_pkg::*;
  logic active_r;
  logic active_nxt;
  logic clr_r;
  logic clr_nxt;

  always_comb
  begin
    clr_nxt = 1'b0;
    active_nxt = active_r;
    // R13 clear then flag
    if (!active_r && !clr_r && i_flr_req)
      clr_nxt = 1'b1;
    if (clr_r)
      active_nxt = 1'b1;
    // R15 completion releases
    else if (active_r && i_done)
      active_nxt = 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      active_r <= 1'b0;
      clr_r <= 1'b0;
    end
    else
    begin
      active_r <= active_nxt;
      clr_r <= clr_nxt;
    end
  end

  assign o_clear_ctl = clr_r;
  assign o_active = active_r;

  // R13 clear precedes active
  a_flr_order: assert property (@(posedge i_clk) disable iff (i_rst) // R13
    $rose(active_r) |-> $past(clr_r))
    else $error("active rose without control clear");
  // R15 done drops active
  a_flr_release: assert property (@(posedge i_clk) disable iff (i_rst) // R15
    (active_r && i_done && !clr_r) |=> !active_r)
    else $error("active not released after done");
endmodule

/* File: hdl/prfs_sequencer.sv */
`timescale 1ns/1ps
// Overview of operation
// R1 - Resets derive from power-on and fundamental pins
// R2 - Hold resets until application clock in use
// R3 - Release config and soft reset after 32
// R4 - Then drop reset status to application
// R5 - Application reset released 32 cycles later
// R6 - Receive PLL lock moves Quiet to Active
// R7 - Detect done: status pulse with status 3
// R8 - Detection done moves Active to Polling
// R9 - Receive reset held until 3 ms detect
// R10 - Power-on release drops transceiver serdes reset
// R11 - Transmit reset waits 127 stable lock cycles
// R12 - Host stops traffic then writes reset bit
// R13 - Clear function controls, then flag reset active
// R14 - Application cleans up, then signals completion
// R15 - Completion deasserts function reset active
// R16 - Output clock follows width, rate, interface
// R17 - Downtrain keeps configured clock, throttles interface
// R18 - Application clock not slower than output clock
// R19 - Data link runs independent of PHY clock
// R20 - Output clock 62.5/125/250, application 125/250
// R21 - Application reset async assert, counted release
module prfs_sequencer (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_por_n,
  input wire logic i_perst_n,
  input wire logic i_clk_inuse,
  input wire prfs_pkg::prfs_cfg_s i_cfg,
  input wire prfs_pkg::prfs_phy_s i_phy,
  input wire logic [3:0] i_link_width,
  input wire logic [prfs_pkg::NUM_FUNC-1:0] i_flr_req,
  input wire logic [prfs_pkg::NUM_FUNC-1:0] i_flr_done,
  output logic o_cfg_rst,
  output logic o_soft_rst,
  output logic o_reset_status,
  output logic o_serdes_rst,
  output logic o_rx_digrst,
  output logic o_tx_digrst,
  output prfs_pkg::prfs_lt_e o_ltssm,
  output logic [1:0] o_clk_sel,
  output logic o_throttle,
  output logic [prfs_pkg::NUM_FUNC-1:0] o_flr_clear,
  output logic [prfs_pkg::NUM_FUNC-1:0] o_flr_active
);
  import prfs_pkg::*;

  // R19 PHY signals resynchronised
  logic [1:0] por_s_r;
  logic [1:0] perst_s_r;
  logic [1:0] inuse_s_r;
  logic [1:0] sigdet_s_r;
  logic [1:0] rxlk_s_r;
  logic [1:0] txlk_s_r;
  logic [1:0] phys_s_r;
  logic [2:0] rxst_a_r;
  logic [2:0] rxst_b_r;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      por_s_r <= 2'h0;
      perst_s_r <= 2'h0;
      inuse_s_r <= 2'h0;
      sigdet_s_r <= 2'h0;
      rxlk_s_r <= 2'h0;
      txlk_s_r <= 2'h0;
      phys_s_r <= 2'h0;
      rxst_a_r <= 3'h0;
      rxst_b_r <= 3'h0;
    end
    else
    begin
      por_s_r <= {por_s_r[0], i_por_n};
      perst_s_r <= {perst_s_r[0], i_perst_n};
      inuse_s_r <= {inuse_s_r[0], i_clk_inuse};
      sigdet_s_r <= {sigdet_s_r[0], i_phy.sigdet};
      rxlk_s_r <= {rxlk_s_r[0], i_phy.rx_locked};
      txlk_s_r <= {txlk_s_r[0], i_phy.tx_locked};
      phys_s_r <= {phys_s_r[0], i_phy.phystatus};
      rxst_a_r <= i_phy.rxstatus;
      rxst_b_r <= rxst_a_r;
    end
  end

  // R1 reset from pins
  logic pin_rst;
  assign pin_rst = !por_s_r[1] || !perst_s_r[1];

  // Hard reset release chain
  prfs_rs_e rs_r;
  prfs_rs_e rs_nxt;
  logic [5:0] rcnt_r;
  logic [5:0] rcnt_nxt;

  always_comb
  begin
    rs_nxt = rs_r;
    rcnt_nxt = rcnt_r;
    case (rs_r)
      PRFS_RS_HOLD:
        if (!pin_rst)
          rs_nxt = PRFS_RS_WAIT;
      // R2 wait clock in use
      PRFS_RS_WAIT:
        if (inuse_s_r[1])
        begin
          rs_nxt = PRFS_RS_COUNT;
          rcnt_nxt = 6'h0;
        end
      // R3 count 32 cycles
      PRFS_RS_COUNT:
      begin
        rcnt_nxt = rcnt_r + 6'h1;
        if (rcnt_r == 6'(CFG_REL_CYCLES - 1))
          rs_nxt = PRFS_RS_RUN;
      end
      PRFS_RS_RUN:
        rs_nxt = PRFS_RS_RUN;
      default:
        rs_nxt = PRFS_RS_HOLD;
    endcase
    if (pin_rst)
      rs_nxt = PRFS_RS_HOLD;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rs_r <= PRFS_RS_HOLD;
      rcnt_r <= 6'h0;
    end
    else
    begin
      rs_r <= rs_nxt;
      rcnt_r <= rcnt_nxt;
    end
  end

  logic core_rst_r;
  logic status_r;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      core_rst_r <= 1'b1;
      status_r <= 1'b1;
    end
    else
    begin
      core_rst_r <= (rs_nxt != PRFS_RS_RUN);
      // R4 status follows release
      status_r <= core_rst_r;
    end
  end
  assign o_cfg_rst = core_rst_r;
  assign o_soft_rst = core_rst_r;
  assign o_reset_status = status_r;

  // R10 serdes reset follows power-on
  logic serdes_rst_r;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      serdes_rst_r <= 1'b1;
    else
      serdes_rst_r <= !por_s_r[1];
  end
  assign o_serdes_rst = serdes_rst_r;

  // R11 transmit lock stability
  logic [6:0] txcnt_r;
  logic [6:0] txcnt_nxt;
  always_comb
  begin
    txcnt_nxt = txcnt_r;
    if (serdes_rst_r || !txlk_s_r[1])
      txcnt_nxt = 7'h0;
    else if (txcnt_r != 7'(TXPLL_CYCLES))
      txcnt_nxt = txcnt_r + 7'h1;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      txcnt_r <= 7'h0;
    else
      txcnt_r <= txcnt_nxt;
  end
  assign o_tx_digrst = (txcnt_r != 7'(TXPLL_CYCLES));

  // Link training
  prfs_lt_e lt_r;
  prfs_lt_e lt_nxt;
  logic det_done;
  // R7 receiver detect complete
  assign det_done = phys_s_r[1] && (rxst_b_r == RXSTAT_DETECTED);

  always_comb
  begin
    lt_nxt = lt_r;
    case (lt_r)
      PRFS_LT_IDLE:
        if (!core_rst_r)
          lt_nxt = PRFS_LT_QUIET;
      // R6 lock leaves quiet
      PRFS_LT_QUIET:
        if (rxlk_s_r[1])
          lt_nxt = PRFS_LT_ACTIVE;
      // R8 detection to polling
      PRFS_LT_ACTIVE:
        if (det_done)
          lt_nxt = PRFS_LT_POLL;
      PRFS_LT_POLL:
        lt_nxt = PRFS_LT_POLL;
      default:
        lt_nxt = PRFS_LT_IDLE;
    endcase
    if (core_rst_r)
      lt_nxt = PRFS_LT_IDLE;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      lt_r <= PRFS_LT_IDLE;
    else
      lt_r <= lt_nxt;
  end
  assign o_ltssm = lt_r;

  // R9 signal detect 3 ms stable
  logic [31:0] sdcnt_r;
  logic [31:0] sdcnt_nxt;
  logic rxrst_r;
  logic rxrst_nxt;
  always_comb
  begin
    sdcnt_nxt = sdcnt_r;
    rxrst_nxt = rxrst_r;
    if (lt_r != PRFS_LT_POLL || !sigdet_s_r[1])
    begin
      sdcnt_nxt = 32'h0;
      rxrst_nxt = 1'b1;
    end
    else if (sdcnt_r != 32'(SIGDET_CYCLES))
      sdcnt_nxt = sdcnt_r + 32'h1;
    else
      rxrst_nxt = 1'b0;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sdcnt_r <= 32'h0;
      rxrst_r <= 1'b1;
    end
    else
    begin
      sdcnt_r <= sdcnt_nxt;
      rxrst_r <= rxrst_nxt;
    end
  end
  assign o_rx_digrst = rxrst_r;

  // R16 R20 clock select from configuration
  // R17 configured values kept on downtrain
  logic [1:0] csel_r;
  logic [1:0] csel_nxt;
  logic thr_r;
  always_comb
  begin
    csel_nxt = CLKSEL_125M;
    if ((i_cfg.width == 4'h8 && i_cfg.rate == GEN3 && i_cfg.wide_if) ||
        (i_cfg.width == 4'h8 && i_cfg.rate == GEN2 && !i_cfg.wide_if) ||
        (i_cfg.width == 4'h4 && i_cfg.rate == GEN3 && !i_cfg.wide_if))
      csel_nxt = CLKSEL_250M;
    else if (i_cfg.width == 4'h1 && i_cfg.rate == GEN1)
      csel_nxt = CLKSEL_62M5;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      csel_r <= CLKSEL_125M;
      thr_r <= 1'b0;
    end
    else
    begin
      if (core_rst_r)
        csel_r <= csel_nxt;
      thr_r <= (lt_r == PRFS_LT_POLL) && (i_link_width < i_cfg.width);
    end
  end
  assign o_clk_sel = csel_r;
  assign o_throttle = thr_r;

  // R13 R15 function-level reset channels
  genvar g;
  generate
    for (g = 0; g < NUM_FUNC; g++)
    begin : g_flr
      prfs_flr_chan u_chan (
        .i_clk(i_clk),
        .i_rst(i_rst || core_rst_r),
        .i_flr_req(i_flr_req[g]),
        .i_done(i_flr_done[g]),
        .o_clear_ctl(o_flr_clear[g]),
        .o_active(o_flr_active[g])
      );
    end
  endgenerate

  sequence s_inuse_seen;
    (rs_r == PRFS_RS_WAIT) && inuse_s_r[1] && !pin_rst;
  endsequence
  a_cfg_release: assert property (@(posedge i_clk) // R3
    disable iff (i_rst || pin_rst)
    s_inuse_seen |-> ##32 core_rst_r ##1 !core_rst_r)
    else $error("config reset not released after 32 cycles");
  a_hold_inuse: assert property (@(posedge i_clk) disable iff (i_rst) // R2
    (rs_r == PRFS_RS_WAIT) |-> core_rst_r)
    else $error("reset released before clock in use");
  a_status_after: assert property (@(posedge i_clk) disable iff (i_rst) // R4
    $fell(core_rst_r) |=> !status_r)
    else $error("status not released after core reset");
  a_pin_reset: assert property (@(posedge i_clk) disable iff (i_rst) // R1
    pin_rst |=> core_rst_r)
    else $error("pin reset did not hold core");
  a_serdes_por: assert property (@(posedge i_clk) disable iff (i_rst) // R10
    por_s_r[1] |=> !serdes_rst_r)
    else $error("serdes reset not released");
  a_tx_stable: assert property (@(posedge i_clk) disable iff (i_rst) // R11
    $fell(o_tx_digrst) |-> $past(txlk_s_r[1], 127))
    else $error("transmit reset released early");
  a_lt_detect: assert property (@(posedge i_clk) disable iff (i_rst) // R8
    (lt_r == PRFS_LT_ACTIVE && det_done && !core_rst_r)
      |=> lt_r == PRFS_LT_POLL)
    else $error("detect did not enter polling");
  a_lt_quiet: assert property (@(posedge i_clk) disable iff (i_rst) // R6
    (lt_r == PRFS_LT_QUIET && rxlk_s_r[1] && !core_rst_r)
      |=> lt_r == PRFS_LT_ACTIVE)
    else $error("lock did not leave quiet");
  a_rx_hold: assert property (@(posedge i_clk) disable iff (i_rst) // R9
    !sigdet_s_r[1] |=> rxrst_r)
    else $error("receive reset dropped without detect");
endmodule

/* File: tb/prfs_app_model.sv */
`timescale 1ns/1ps
module prfs_app_model (
  input wire logic i_clk,
  input wire logic i_reset_status,
  input wire logic [prfs_pkg::NUM_FUNC-1:0] i_flr_active,
  input wire logic [prfs_pkg::NUM_FUNC-1:0] i_slow,
  output logic o_app_rst_n,
  output logic [prfs_pkg::NUM_FUNC-1:0] o_flr_done
);
  import prfs_pkg::*;
  logic [5:0] rst_cnt_r;
  logic [3:0] wait_r [NUM_FUNC];
  always_ff @(posedge i_clk or posedge i_reset_status)
  begin
    if (i_reset_status)
    begin
      rst_cnt_r <= 6'h00;
      o_app_rst_n <= 1'b0;
    end
    else if (rst_cnt_r != 6'h20)
    begin
      rst_cnt_r <= rst_cnt_r + 6'h01;
      o_app_rst_n <= (rst_cnt_r == 6'h1F);
    end
  end
  always_ff @(posedge i_clk)
  begin
    for (int f = 0; f < NUM_FUNC; f++)
    begin
      if (!i_flr_active[f])
      begin
        wait_r[f] <= 4'h0;
        o_flr_done[f] <= 1'b0;
      end
      else if (wait_r[f] == (i_slow[f] ? 4'h9 : 4'h1))
        o_flr_done[f] <= 1'b1;
      else
        wait_r[f] <= wait_r[f] + 4'h1;
    end
  end
endmodule

/* File: tb/prfs_sequencer_bench.sv */
`timescale 1ns/1ps
module prfs_sequencer_bench;
  import prfs_pkg::*;
  logic i_clk, i_rst, i_por_n, i_perst_n, i_clk_inuse, app_rst_n;
  prfs_cfg_s i_cfg;
  prfs_phy_s i_phy;
  logic [3:0] i_link_width, i_flr_req, i_flr_done, slow;
  logic [3:0] o_flr_clear, o_flr_active;
  logic o_cfg_rst, o_soft_rst, o_reset_status, o_serdes_rst;
  logic o_rx_digrst, o_tx_digrst, o_throttle;
  prfs_lt_e o_ltssm;
  logic [1:0] o_clk_sel;
  int errors, checks_done, n;
  logic [3:0] exp_q[$];
  // Width, rate, wide interface, expected clock select
  logic [8:0] tbl [9] = '{9'h020, 9'h101, 9'h089, 9'h10A, 9'h10D,
    9'h051, 9'h092, 9'h095, 9'h116};

  prfs_sequencer uut (.i_clk(i_clk), .i_rst(i_rst), .i_por_n(i_por_n),
    .i_perst_n(i_perst_n), .i_clk_inuse(i_clk_inuse), .i_cfg(i_cfg),
    .i_phy(i_phy), .i_link_width(i_link_width), .i_flr_req(i_flr_req),
    .i_flr_done(i_flr_done), .o_cfg_rst(o_cfg_rst),
    .o_soft_rst(o_soft_rst), .o_reset_status(o_reset_status),
    .o_serdes_rst(o_serdes_rst), .o_rx_digrst(o_rx_digrst),
    .o_tx_digrst(o_tx_digrst), .o_ltssm(o_ltssm), .o_clk_sel(o_clk_sel),
    .o_throttle(o_throttle), .o_flr_clear(o_flr_clear),
    .o_flr_active(o_flr_active));

  prfs_app_model app (.i_clk(i_clk), .i_reset_status(o_reset_status),
    .i_flr_active(o_flr_active), .i_slow(slow), .o_app_rst_n(app_rst_n),
    .o_flr_done(i_flr_done));

  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask

  task automatic limit(input int cnt, input int lim);
    if (cnt >= lim)
    begin
      errors++;
      $display("ERROR %0t: wait ran out", $time);
      print_verdict();
    end
  endtask

  // Clear pulses are matched against the oldest noted request
  always @(negedge i_clk)
  begin
    if (!i_rst && o_flr_clear !== 4'h0)
    begin
      if (exp_q.size() == 0)
        check(o_flr_clear, 4'h0);
      else
        check(o_flr_clear, exp_q.pop_front());
      check(o_flr_clear & o_flr_active, 4'h0);
    end
  end

  initial
  begin
    {i_rst, i_por_n, i_perst_n, i_clk_inuse} = 4'h8;
    i_cfg = '0;
    i_phy = '0;
    i_link_width = 4'h8;
    i_flr_req = 4'h0;
    slow = 4'h0;
    errors = 0;
    checks_done = 0;
    void'($urandom(31270));
    step(5);
    foreach (tbl[k])
    begin
      i_cfg = prfs_cfg_s'(tbl[k][8:2]);
      i_rst = 1'b1;
      step(2);
      i_rst = 1'b0;
      step(6);
      check(o_clk_sel, tbl[k][1:0]);
    end
    check({o_serdes_rst, o_tx_digrst, o_rx_digrst}, 3'h7);
    check(o_ltssm, PRFS_LT_IDLE);
    {i_por_n, i_perst_n} = 2'h3;
    step(40);
    check(o_serdes_rst, 1'b0);
    check({o_cfg_rst, o_soft_rst, o_reset_status}, 3'h7);
    i_clk_inuse = 1'b1;
    for (n = 0; n < 60 && o_cfg_rst !== 1'b0; n++) step(1);
    limit(n, 60);
    check(n >= 32 && n <= 36, 1'b1);
    check({o_soft_rst, o_reset_status}, 2'h1);
    step(1);
    check(o_reset_status, 1'b0);
    step(31);
    check(app_rst_n, 1'b0);
    step(1);
    check(app_rst_n, 1'b1);
    for (n = 0; n < 10 && o_ltssm !== PRFS_LT_QUIET; n++) step(1);
    limit(n, 10);
    i_phy.rx_locked = 1'b1;
    for (n = 0; n < 6 && o_ltssm !== PRFS_LT_ACTIVE; n++) step(1);
    check(o_ltssm, PRFS_LT_ACTIVE);
    repeat (3)
    begin
      n = $urandom % 7;
      i_phy.rxstatus = (n >= 3) ? 3'(n + 1) : 3'(n);
      i_phy.phystatus = 1'b1;
      step(1);
      i_phy.phystatus = 1'b0;
      step(5);
      check(o_ltssm, PRFS_LT_ACTIVE);
    end
    i_phy.rxstatus = RXSTAT_DETECTED;
    i_phy.phystatus = 1'b1;
    step(1);
    i_phy.phystatus = 1'b0;
    for (n = 0; n < 6 && o_ltssm !== PRFS_LT_POLL; n++) step(1);
    check(o_ltssm, PRFS_LT_POLL);
    step(2);
    check(o_throttle, 1'b0);
    i_link_width = 4'h4;
    step(4);
    check({o_throttle, o_clk_sel}, 3'h6);
    i_phy.sigdet = 1'b1;
    step(1000);
    check(o_rx_digrst, 1'b1);
    i_phy.tx_locked = 1'b1;
    step(125);
    i_phy.tx_locked = 1'b0;
    step(4);
    check(o_tx_digrst, 1'b1);
    i_phy.tx_locked = 1'b1;
    for (n = 0; n < 200 && o_tx_digrst !== 1'b0; n++) step(1);
    limit(n, 200);
    check(n >= 127 && n <= 132, 1'b1);
    slow = 4'($urandom);
    for (int f = 0; f < NUM_FUNC; f++)
    begin
      exp_q.push_back(4'h1 << f);
      i_flr_req[f] = 1'b1;
      step(1);
      i_flr_req[f] = 1'b0;
      for (n = 0; n < 5 && o_flr_active[f] !== 1'b1; n++) step(1);
      check(o_flr_active, 4'h1 << f);
      i_flr_req[f] = 1'b1;
      step(1);
      i_flr_req[f] = 1'b0;
      for (n = 0; n < 30 && o_flr_active[f] !== 1'b0; n++) step(1);
      limit(n, 30);
      check(i_flr_done[f], 1'b1);
      step(3);
    end
    check(exp_q.size(), 0);
    print_verdict();
  end
endmodule
